// [dv/defect_map_store.sv]
`timescale 1ns/1ps
`default_nettype none
module defect_map_store #(
  parameter int PIX_W = 14,
  parameter int ADDR_W = 20,
  parameter logic [7:0] FILE_ID = 8'h70
) (
  input wire logic [7:0] map_file,
  input wire logic [ADDR_W-1:0] map_addr,
  output logic map_defect,
  output logic [PIX_W-1:0] map_word
);
  // only the selected file marks pixels, every odd index is defective
  assign map_defect = (map_file == FILE_ID) && map_addr[0];
  assign map_word = PIX_W'(map_addr * 7 + 3);
endmodule : defect_map_store
`default_nettype wire

// [dv/test_thermal_pixel_correction_stages.sv]
`timescale 1ns/1ps
`default_nettype none
module test_thermal_pixel_correction_stages;
  logic clk, rst_n, in_valid, in_ready, in_sof, map_defect, cal_done, temp_valid, cfg_we, cfg_re;
  logic cfg_rvalid, integ_busy, out_valid, out_ready, src_mode, src_seen;
  logic [13:0] in_data, bg_image, map_word, out_data, d, b, e, src_prev;
  logic [83:0] nb_data, nbv;
  logic [5:0] nb_good, ngv;
  logic [7:0] map_file;
  logic [19:0] map_addr;
  logic [15:0] cal_mean, temp_value, cfg_wdata, cfg_rdata, sl;
  logic [3:0] cfg_sel;
  logic [1:0] rmode;
  logic [13:0] hi_q[$], lo_q[$];
  logic [15:0] rd_q[$];
  int failures, cmp_count, mx, off, sum, cnt;
  thermal_pixel_correction_stages i_thermal_pixel_correction_stages (.clk(clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_sof(in_sof), .bg_image(bg_image), .nb_data(nb_data), .nb_good(nb_good),
    .map_file(map_file), .map_addr(map_addr), .map_defect(map_defect), .map_word(map_word), .cal_done(cal_done),
    .cal_mean(cal_mean), .temp_valid(temp_valid), .temp_value(temp_value), .cfg_we(cfg_we), .cfg_re(cfg_re),
    .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .integ_busy(integ_busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  defect_map_store i_defect_map_store (.map_file(map_file), .map_addr(map_addr), .map_defect(map_defect),
    .map_word(map_word));
  // clock and downstream stall pattern
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) out_ready = (rmode == 2'h0) || (rmode == 2'h1 && $urandom_range(1) == 1);
  // ==========================================================
  // helpers
  function automatic logic [13:0] sat(input int v, input int m);
    return (v < 0) ? 14'h0000 : (v > m) ? 14'(m) : 14'(v);
  endfunction
  task automatic chk(input string what, input logic [15:0] x, input logic [15:0] s);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, x, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [3:0] s, input logic [15:0] v);
    @(negedge clk);
    cfg_we = 1'b1;
    cfg_sel = s;
    cfg_wdata = v;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] s, input logic [15:0] v);
    @(negedge clk);
    cfg_re = 1'b1;
    cfg_sel = s;
    rd_q.push_back(v);
    @(negedge clk);
    cfg_re = 1'b0;
  endtask : rd
  task automatic pix(input logic [13:0] dv, input logic [13:0] bv, input logic sof, input logic [13:0] hi,
                     input logic [13:0] lo);
    @(negedge clk);
    in_valid = 1'b1;
    in_data = dv;
    bg_image = bv;
    in_sof = sof;
    nb_data = nbv;
    nb_good = ngv;
    hi_q.push_back(hi);
    lo_q.push_back(lo);
    do @(posedge clk); while (in_ready !== 1'b1);
  endtask : pix
  task automatic drain(input string name);
    @(negedge clk);
    in_valid = 1'b0;
    for (int i = 0; i < 60 && hi_q.size() + rd_q.size() != 0; i++) @(negedge clk);
    chk("queue empty", 16'h0000, 16'(hi_q.size() + rd_q.size()));
    $display("test %s done", name);
  endtask : drain
  // output watcher takes the oldest note for every result
  always @(posedge clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready === 1'b1 && !src_mode) begin
      if (hi_q.size() == 0) chk("stray pixel", 16'h0000, 16'h0001);
      else begin
        chk("pixel", {2'h0, (out_data === lo_q[0]) ? lo_q[0] : hi_q[0]}, {2'h0, out_data});
        void'(hi_q.pop_front());
        void'(lo_q.pop_front());
      end
    end
    // test source words come from consecutive map indices
    if (!src_mode) src_seen = 1'b0;
    else if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (src_seen) chk("test word", {2'h0, src_prev + 14'h0007}, {2'h0, out_data});
      src_prev = out_data;
      src_seen = 1'b1;
    end
    if (cfg_rvalid === 1'b1) chk("read data", (rd_q.size() != 0) ? rd_q.pop_front() : 16'hDEAD, cfg_rdata);
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    end_of_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    {rst_n, in_valid, in_sof, cal_done, temp_valid, cfg_we, cfg_re, src_mode} = 8'h00;
    {in_data, bg_image, nbv, ngv, nb_data, nb_good, cal_mean, temp_value, cfg_wdata, cfg_sel} = '0;
    rmode = 2'h0;
    void'($urandom(32'hCDA11318));
    repeat (3) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    foreach (rd_q[i]) rd_q.delete();
    for (int s = 0; s < 11; s++) rd(4'(s), (s == 3) ? 16'h0070 : (s == 9) ? 16'h0001 : 16'h0000);
    wr(4'hA, 16'hFFFF);
    rd(4'hA, 16'h0000);
    drain("reset values");
    rmode = 2'h1;
    for (int i = 0; i < 16; i++) begin
      d = 14'($urandom);
      pix(d, 14'h0000, i == 0, d, d);
    end
    drain("pass through");
    rmode = 2'h2;
    pix(14'h0011, 14'h0000, 1'b0, 14'h0011, 14'h0011);
    pix(14'h0022, 14'h0000, 1'b0, 14'h0022, 14'h0022);
    @(negedge clk) chk("in_ready full", 16'h0000, {15'h0000, in_ready});
    rmode = 2'h1;
    pix(14'h0033, 14'h0000, 1'b0, 14'h0033, 14'h0033);
    drain("buffer full");
    wr(thermal_pkg::SEL_BG_OFFSET, 16'h1230);
    wr(thermal_pkg::SEL_BG_CONTROL, 16'h0001);
    for (int m = 0; m < 2; m++) begin
      wr(thermal_pkg::SEL_PIXEL_MODE, 16'(m));
      mx = m ? 16383 : 4095;
      off = m ? 16'h1230 >> 2 : 16'h1230 >> 4;
      for (int i = 0; i < 10; i++) begin
        d = (i == 1) ? 14'(mx) : (i == 0) ? 14'h0000 : 14'($urandom) & 14'(mx);
        b = (i == 0) ? 14'(mx) : (i == 1) ? 14'h0000 : 14'($urandom) & 14'(mx);
        e = sat(int'(d) - int'(b) + off, mx);
        pix(d, b, 1'b0, e, e);
      end
      drain("background offset");
    end
    wr(thermal_pkg::SEL_BG_CONTROL, 16'h0002);
    pix(14'h0123, 14'h2ABC, 1'b0, 14'h2ABC, 14'h2ABC);
    drain("background image");
    wr(thermal_pkg::SEL_BG_CONTROL, 16'h0005);
    rd(thermal_pkg::SEL_BG_CONTROL, 16'h8005);
    rd(thermal_pkg::SEL_BG_OFFSET, 16'h1230);
    for (int i = 0; i < 2; i++) pix(14'h1000, 14'h0800, 1'b1, 14'h0C8C, 14'h0C8C);
    drain("integration");
    rd(thermal_pkg::SEL_BG_CONTROL, 16'h0005);
    for (int p = 0; p < 2; p++) begin
      wr(thermal_pkg::SEL_OFFSET_POLICY, 16'(p));
      @(negedge clk) cal_done = 1'b1;
      cal_mean = 16'h2468 + 16'(p);
      @(negedge clk) cal_done = 1'b0;
      rd(thermal_pkg::SEL_BG_OFFSET, p ? 16'h2469 : 16'h1230);
    end
    wr(thermal_pkg::SEL_BG_CONTROL, 16'h0000);
    drain("calibration offset");
    for (int k = 0; k < 3; k++) begin
      wr(thermal_pkg::SEL_DEFECT_MODE, (k == 0) ? 16'h0000 : 16'h0001);
      wr(thermal_pkg::SEL_DEFECT_FILE, (k == 2) ? 16'h0071 : 16'h0070);
      @(negedge clk);
      chk("map file", (k == 2) ? 16'h0071 : 16'h0070, {8'h00, map_file});
      for (int i = 0; i < 8; i++) begin
        d = 14'($urandom);
        nbv = 84'({$urandom, $urandom, $urandom});
        ngv = (i == 3) ? 6'h00 : 6'($urandom);
        {sum, cnt} = '0;
        for (int j = 0; j < 6; j++) if (ngv[j]) begin
          sum += int'(nbv[j*14+:14]);
          cnt++;
        end
        e = (k == 1 && i[0] && cnt != 0) ? 14'(sum / cnt) : d;
        pix(d, 14'h0000, i == 0, e, (e != d) ? e - 14'h0001 : e);
      end
      drain("defect fix");
    end
    rmode = 2'h0;
    src_mode = 1'b1;
    wr(thermal_pkg::SEL_DEFECT_MODE, 16'h0002);
    repeat (4) @(negedge clk);
    chk("test ready", 16'h0001, {15'h0000, in_ready});
    chk("test valid", 16'h0001, {15'h0000, out_valid});
    wr(thermal_pkg::SEL_DEFECT_MODE, 16'h0000);
    repeat (6) @(negedge clk);
    src_mode = 1'b0;
    temp_value = 16'h0140;
    temp_valid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      sl = (k == 1) ? 16'hFF80 : 16'h0040;
      wr(thermal_pkg::SEL_DRIFT_SLOPE, sl);
      wr(thermal_pkg::SEL_DRIFT_INTERCEPT, 16'hFFF6);
      wr(thermal_pkg::SEL_DRIFT_USER, 16'h0005);
      wr(thermal_pkg::SEL_DRIFT_CONTROL, (k == 2) ? 16'h0010 : (k == 3) ? 16'h0001 : 16'h0011);
      // the eighth-step filter settles at 313 for a steady 320, its step rounding down
      off = (k == 2) ? 0 : ((int'($signed(sl)) * ((k == 3) ? 313 : 320)) >>> 10) - 10 + 5;
      for (int i = 0; i < 8; i++) begin
        d = (i == 0) ? ((k == 1) ? 14'h0000 : 14'h3FFF) : 14'($urandom);
        e = sat(int'(d) + off, 16383);
        pix(d, 14'h0000, 1'b0, e, e);
      end
      drain("drift offset");
    end
    end_of_test();
  end
endmodule : test_thermal_pixel_correction_stages
`default_nettype wire

// [dv/thermal_pixel_correction_stages_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module thermal_pixel_correction_stages_sva #(
  parameter int PIX_W = 14,
  parameter int ADDR_W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [PIX_W-1:0] in_data,
  input wire logic [7:0] map_file,
  input wire logic cfg_we,
  input wire logic cfg_re,
  input wire logic [3:0] cfg_sel,
  input wire logic [15:0] cfg_wdata,
  input wire logic cfg_rvalid,
  input wire logic [15:0] cfg_rdata,
  input wire logic integ_busy,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [PIX_W-1:0] out_data
);
  logic [4:0] bg_ctl;
  logic [1:0] def_mode;
  logic drift_en;
  logic wr_bg;
  // ==========================================================
  // shadow of the mode fields written through the parameter port
  assign wr_bg = cfg_we && cfg_sel == thermal_pkg::SEL_BG_CONTROL;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bg_ctl <= 5'h00;
      def_mode <= 2'h0;
      drift_en <= 1'b0;
    end else if (cfg_we) begin
      if (wr_bg) bg_ctl <= cfg_wdata[4:0];
      if (cfg_sel == thermal_pkg::SEL_DEFECT_MODE) def_mode <= cfg_wdata[1:0];
      if (cfg_sel == thermal_pkg::SEL_DRIFT_CONTROL) drift_en <= cfg_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // port relations
  a_read_answer: assert property (cfg_re |=> cfg_rvalid)
    else $error("read answer missing");
  a_no_stray_answer: assert property (!cfg_re |=> !cfg_rvalid)
    else $error("read answer without a read");
  a_busy_in_msb: assert property (cfg_re && cfg_sel == thermal_pkg::SEL_BG_CONTROL ##1 $stable(integ_busy)
    |-> cfg_rdata[15] == integ_busy) else $error("busy bit wrong in control read");
  a_integ_start: assert property (wr_bg && cfg_wdata[4:2] != 3'h0 && cfg_wdata[4:2] != bg_ctl[4:2] |=> integ_busy)
    else $error("integration did not start");
  a_file_track: assert property (cfg_we && cfg_sel == thermal_pkg::SEL_DEFECT_FILE
    |-> ##2 {8'h00, map_file} == ($past(cfg_wdata, 2) & 16'h00FF)) else $error("map file not updated");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output changed while stalled");
  a_full_only: assert property (!in_ready && $past(rst_n) |-> out_valid)
    else $error("input refused with empty buffer");
  a_pass_through: assert property (in_valid && in_ready && !out_valid && bg_ctl[1:0] == 2'h0
    && def_mode == 2'h0 && !drift_en |=> out_valid && out_data == $past(in_data)) else $error("pass data changed");
  a_test_ready: assert property (def_mode == 2'h2 |-> in_ready)
    else $error("test mode refused input");
endmodule : thermal_pixel_correction_stages_sva
bind thermal_pixel_correction_stages thermal_pixel_correction_stages_sva #(.PIX_W(PIX_W), .ADDR_W(ADDR_W))
  i_thermal_pixel_correction_stages_sva (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
  .in_data(in_data), .map_file(map_file), .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_sel(cfg_sel),
  .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .integ_busy(integ_busy),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
`default_nettype wire

// [hw/pixel_skid_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module pixel_skid_buffer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data
);
  // =====================================================================
  // two-entry store: head feeds the output, tail catches the word in flight
  logic [W-1:0] tail;
  logic [1:0] count;
  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  initial begin
    if (W < 1) $error("pixel_skid_buffer: W must be positive");
  end

  // occupancy and ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 2'h0;
      s_ready <= 1'b0;
      m_valid <= 1'b0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
      s_ready <= (count + {1'b0, push} - {1'b0, pop}) < 2'h2;
      m_valid <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end

  // data movement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      m_data <= '0;
      tail <= '0;
    end else begin
      if (push && (count == 2'h0 || (count == 2'h1 && pop))) m_data <= s_data;
      else if (pop && count == 2'h2) m_data <= tail;
      if (push && ((count == 2'h1 && !pop) || count == 2'h2)) tail <= s_data;
    end
  end
endmodule : pixel_skid_buffer
`default_nettype wire

// [hw/thermal_pixel_correction_stages.sv]
`timescale 1ns/1ps
`default_nettype none
module thermal_pixel_correction_stages #(
  parameter int PIX_W = 14,
  parameter int ADDR_W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  // upstream pixel stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [PIX_W-1:0] in_data,
  input wire logic in_sof,
  input wire logic [PIX_W-1:0] bg_image,
  input wire logic [6*PIX_W-1:0] nb_data,
  input wire logic [5:0] nb_good,
  // defect map store
  output logic [7:0] map_file,
  output logic [ADDR_W-1:0] map_addr,
  input wire logic map_defect,
  input wire logic [PIX_W-1:0] map_word,
  // calibration and temperature
  input wire logic cal_done,
  input wire logic [15:0] cal_mean,
  input wire logic temp_valid,
  input wire logic [15:0] temp_value,
  // host parameter port
  input wire logic cfg_we,
  input wire logic cfg_re,
  input wire logic [3:0] cfg_sel,
  input wire logic [15:0] cfg_wdata,
  output logic cfg_rvalid,
  output logic [15:0] cfg_rdata,
  output logic integ_busy,
  // downstream pixel stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [PIX_W-1:0] out_data
);
  initial begin
    if (PIX_W != 14) $error("PIX_W must be 14: 12-bit mode is a runtime setting");
    if (ADDR_W < 1 || ADDR_W > 31) $error("ADDR_W out of range");
  end

  // =====================================================================
  // parameter registers
  logic [15:0] background_correction_control;
  logic [15:0] background_offset;
  logic [1:0] defect_fix_mode;
  logic [7:0] defect_table_file_select;
  logic [7:0] drift_control;
  logic [15:0] drift_slope;
  logic [15:0] drift_intercept;
  logic [15:0] drift_user_offset;
  logic offset_policy;
  logic pix14;
  logic [6:0] frames_left;
  logic sync_a;
  logic sync_b;
  logic signed [15:0] temp_raw;
  logic signed [15:0] temp_filt;

  // decode of the parameter port
  wire wr_bg_ctrl = cfg_we && cfg_sel == thermal_pkg::SEL_BG_CONTROL;
  wire wr_bg_off = cfg_we && cfg_sel == thermal_pkg::SEL_BG_OFFSET;
  wire [2:0] new_int = cfg_wdata[thermal_pkg::BG_INT_LSB +: thermal_pkg::BG_INT_W];
  wire [2:0] cur_int = background_correction_control[thermal_pkg::BG_INT_LSB +: thermal_pkg::BG_INT_W];
  wire [1:0] bg_out = background_correction_control[thermal_pkg::BG_OUT_LSB +: thermal_pkg::BG_OUT_W];
  wire int_start = wr_bg_ctrl && new_int != cur_int && new_int != thermal_pkg::INT_NONE;

  // frames per integration, plus one start-of-frame to close the last frame
  logic [6:0] int_frames;
  always_comb begin
    unique case (new_int)
      thermal_pkg::INT_1: int_frames = 7'h02;
      thermal_pkg::INT_8: int_frames = 7'h09;
      thermal_pkg::INT_16: int_frames = 7'h11;
      thermal_pkg::INT_32: int_frames = 7'h21;
      thermal_pkg::INT_64: int_frames = 7'h41;
      default: int_frames = 7'h00;
    endcase
  end

  // register writes; an integration start never touches the offset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      background_correction_control <= thermal_pkg::BG_CONTROL_RESET;
      background_offset <= thermal_pkg::BG_OFFSET_RESET;
      defect_fix_mode <= thermal_pkg::DEFECT_MODE_RESET;
      defect_table_file_select <= thermal_pkg::DEFECT_FILE_RESET;
      drift_control <= thermal_pkg::DRIFT_CONTROL_RESET;
      drift_slope <= thermal_pkg::DRIFT_WORD_RESET;
      drift_intercept <= thermal_pkg::DRIFT_WORD_RESET;
      drift_user_offset <= thermal_pkg::DRIFT_WORD_RESET;
      offset_policy <= 1'b0;
      pix14 <= 1'b1;
    end else begin
      if (wr_bg_ctrl) background_correction_control <= {11'h000, cfg_wdata[4:0]};
      if (cal_done && offset_policy) background_offset <= cal_mean;
      else if (wr_bg_off) background_offset <= cfg_wdata;
      if (cfg_we && cfg_sel == thermal_pkg::SEL_DEFECT_MODE) defect_fix_mode <= cfg_wdata[1:0];
      if (cfg_we && cfg_sel == thermal_pkg::SEL_DEFECT_FILE) defect_table_file_select <= cfg_wdata[7:0];
      if (cfg_we && cfg_sel == thermal_pkg::SEL_DRIFT_CONTROL) drift_control <= cfg_wdata[7:0];
      if (cfg_we && cfg_sel == thermal_pkg::SEL_DRIFT_SLOPE) drift_slope <= cfg_wdata;
      if (cfg_we && cfg_sel == thermal_pkg::SEL_DRIFT_INTERCEPT) drift_intercept <= cfg_wdata;
      if (cfg_we && cfg_sel == thermal_pkg::SEL_DRIFT_USER) drift_user_offset <= cfg_wdata;
      if (cfg_we && cfg_sel == thermal_pkg::SEL_OFFSET_POLICY) offset_policy <= cfg_wdata[0];
      if (cfg_we && cfg_sel == thermal_pkg::SEL_PIXEL_MODE) pix14 <= cfg_wdata[0];
    end
  end

  // =====================================================================
  // integration progress, counted in accepted start-of-frame markers
  wire sof_seen = in_valid && in_ready && in_sof;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frames_left <= 7'h00;
      integ_busy <= 1'b0;
    end else if (int_start) begin
      frames_left <= int_frames;
      integ_busy <= 1'b1;
    end else if (sof_seen && frames_left != 7'h00) begin
      frames_left <= frames_left - 7'h01;
      integ_busy <= frames_left != 7'h01;
    end
  end

  // read port: busy flag sits in the top bit of the control word
  logic [15:0] rd_mux;
  always_comb begin
    unique case (cfg_sel)
      thermal_pkg::SEL_BG_CONTROL: rd_mux = {integ_busy, background_correction_control[14:0]};
      thermal_pkg::SEL_BG_OFFSET: rd_mux = background_offset;
      thermal_pkg::SEL_DEFECT_MODE: rd_mux = {14'h0000, defect_fix_mode};
      thermal_pkg::SEL_DEFECT_FILE: rd_mux = {8'h00, defect_table_file_select};
      thermal_pkg::SEL_DRIFT_CONTROL: rd_mux = {8'h00, drift_control};
      thermal_pkg::SEL_DRIFT_SLOPE: rd_mux = drift_slope;
      thermal_pkg::SEL_DRIFT_INTERCEPT: rd_mux = drift_intercept;
      thermal_pkg::SEL_DRIFT_USER: rd_mux = drift_user_offset;
      thermal_pkg::SEL_OFFSET_POLICY: rd_mux = {15'h0000, offset_policy};
      thermal_pkg::SEL_PIXEL_MODE: rd_mux = {15'h0000, pix14};
      default: rd_mux = 16'h0000;
    endcase
  end

  // read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_rvalid <= 1'b0;
      cfg_rdata <= 16'h0000;
    end else begin
      cfg_rvalid <= cfg_re;
      if (cfg_re) cfg_rdata <= rd_mux;
    end
  end

  // =====================================================================
  // saturating add of a signed offset to a pixel code
  function automatic logic [PIX_W-1:0] sat_add(input logic [PIX_W-1:0] pix, input logic signed [24:0] off,
                                               input logic mode14);
    logic signed [25:0] sum;
    logic signed [25:0] top;
    sum = $signed({12'h000, pix}) + {off[24], off};
    top = mode14 ? 26'sh0003FFF : 26'sh0000FFF;
    if (sum < 26'sh0) sat_add = '0;
    else if (sum > top) sat_add = top[PIX_W-1:0];
    else sat_add = sum[PIX_W-1:0];
  endfunction : sat_add

  // background stage: only the upper 12 or 14 offset bits count
  wire [PIX_W-1:0] bg_off_used = pix14 ? background_offset[15:2] : {2'h0, background_offset[15:4]};
  wire signed [24:0] bg_term = $signed({11'h000, bg_off_used}) - $signed({11'h000, bg_image});
  logic [PIX_W-1:0] bg_pix;
  always_comb begin
    unique case (bg_out)
      2'h1: bg_pix = sat_add(in_data, bg_term, pix14);
      2'h2: bg_pix = bg_image;
      default: bg_pix = in_data;
    endcase
  end

  // =====================================================================
  // defect stage: mean of the good neighbours among six
  logic [PIX_W-1:0] nb_term [6];
  logic [PIX_W+2:0] nb_sum;
  logic [2:0] nb_cnt;
  logic [15:0] recip;
  logic [PIX_W+18:0] nb_prod;
  genvar gi;
  // neighbour words masked by their good flags
  generate
    for (gi = 0; gi < 6; gi++) begin : g_nb
      assign nb_term[gi] = nb_good[gi] ? nb_data[gi*PIX_W +: PIX_W] : '0;
    end
  endgenerate

  // sum and count of the good neighbours
  always_comb begin
    nb_sum = '0;
    nb_cnt = 3'h0;
    for (int i = 0; i < 6; i++) begin
      nb_sum = nb_sum + {3'h0, nb_term[i]};
      nb_cnt = nb_cnt + {2'h0, nb_good[i]};
    end
  end

  // reciprocal in 0.16, rounded down so the mean is at most one code low
  always_comb begin
    unique case (nb_cnt)
      3'h1: recip = 16'hFFFF;
      3'h2: recip = 16'h8000;
      3'h3: recip = 16'h5555;
      3'h4: recip = 16'h4000;
      3'h5: recip = 16'h3333;
      3'h6: recip = 16'h2AAA;
      default: recip = 16'h0000;
    endcase
  end

  // a lone good neighbour is taken as it is
  logic [PIX_W-1:0] nb_term_one;
  always_comb begin
    nb_term_one = '0;
    for (int i = 0; i < 6; i++) nb_term_one = nb_term_one | nb_term[i];
  end

  // mean by a multiply with the reciprocal
  assign nb_prod = nb_sum * recip;
  wire [PIX_W-1:0] nb_mean = nb_prod[PIX_W+15:16] + {{(PIX_W-1){1'b0}}, nb_cnt == 3'h1};
  wire fix_here = defect_fix_mode == 2'h1 && map_defect && nb_cnt != 3'h0;
  wire [PIX_W-1:0] defect_pix = fix_here ? (nb_cnt == 3'h1 ? nb_term_one : nb_mean) : bg_pix;

  // =====================================================================
  // temperature: two-flop sync of the strobe, then optional smoothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= temp_valid;
      sync_b <= sync_a;
    end
  end

  // filter steps one eighth of the gap to the previous raw sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      temp_raw <= 16'sh0000;
      temp_filt <= 16'sh0000;
    end else if (sync_b) begin
      temp_raw <= $signed(temp_value);
      temp_filt <= temp_filt + ((temp_raw - temp_filt) >>> thermal_pkg::FILTER_SHIFT);
    end
  end

  // drift offset: slope times temperature plus intercept plus user term
  wire signed [15:0] temp_used = drift_control[thermal_pkg::DRIFT_FILTER_BYPASS_BIT] ? temp_raw : temp_filt;
  wire signed [31:0] slope_prod = $signed(drift_slope) * temp_used;
  wire signed [21:0] slope_term = 22'(slope_prod >>> (thermal_pkg::SLOPE_FRAC + thermal_pkg::TEMP_FRAC));
  wire signed [24:0] drift_off = 25'(slope_term) + 25'($signed(drift_intercept))
                                 + 25'($signed(drift_user_offset));
  wire drift_on = drift_control[thermal_pkg::DRIFT_EN_BIT];
  wire [PIX_W-1:0] drift_pix = drift_on ? sat_add(defect_pix, drift_off, pix14) : defect_pix;

  // =====================================================================
  // test source: in mode 2 the map is streamed out and input pixels dropped
  wire test_src = defect_fix_mode == 2'h2;
  logic [ADDR_W-1:0] pix_addr;
  wire buf_ready;
  wire buf_valid = test_src ? 1'b1 : in_valid;
  wire [PIX_W-1:0] buf_data = test_src ? map_word : drift_pix;
  assign in_ready = test_src ? 1'b1 : buf_ready;

  // pixel index: follows accepted pixels, or only the streamed map in test mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pix_addr <= '0;
      map_file <= thermal_pkg::DEFECT_FILE_RESET;
    end else begin
      map_file <= defect_table_file_select;
      if (test_src) begin
        if (buf_ready) pix_addr <= pix_addr + 1'b1;
      end else if (sof_seen) pix_addr <= ADDR_W'(1);
      else if (in_valid && in_ready) pix_addr <= pix_addr + 1'b1;
    end
  end
  // the first pixel of a frame looks up index zero before the counter restarts
  assign map_addr = (in_valid && in_sof && !test_src) ? '0 : pix_addr;

  // output buffer keeps every word when the receiver stalls
  pixel_skid_buffer #(.W(PIX_W)) u_out_buf (
    .clk(clk),
    .rst_n(rst_n),
    .s_valid(buf_valid),
    .s_ready(buf_ready),
    .s_data(buf_data),
    .m_valid(out_valid),
    .m_ready(out_ready),
    .m_data(out_data)
  );
endmodule : thermal_pixel_correction_stages
`default_nettype wire

// [hw/thermal_pkg.sv]
package thermal_pkg;
  // =====================================================================
  // parameter select codes of the command port
  localparam logic [3:0] SEL_BG_CONTROL = 4'h0;
  localparam logic [3:0] SEL_BG_OFFSET = 4'h1;
  localparam logic [3:0] SEL_DEFECT_MODE = 4'h2;
  localparam logic [3:0] SEL_DEFECT_FILE = 4'h3;
  localparam logic [3:0] SEL_DRIFT_CONTROL = 4'h4;
  localparam logic [3:0] SEL_DRIFT_SLOPE = 4'h5;
  localparam logic [3:0] SEL_DRIFT_INTERCEPT = 4'h6;
  localparam logic [3:0] SEL_DRIFT_USER = 4'h7;
  localparam logic [3:0] SEL_OFFSET_POLICY = 4'h8;
  localparam logic [3:0] SEL_PIXEL_MODE = 4'h9;
  // =====================================================================
  // field positions
  localparam int BG_OUT_LSB = 0;
  localparam int BG_OUT_W = 2;
  localparam int BG_INT_LSB = 2;
  localparam int BG_INT_W = 3;
  localparam int BG_BUSY_BIT = 15;
  localparam int DRIFT_EN_BIT = 0;
  localparam int DRIFT_FILTER_BYPASS_BIT = 4;
  localparam int SLOPE_FRAC = 6;
  localparam int TEMP_FRAC = 4;
  localparam int FILTER_SHIFT = 3;
  // =====================================================================
  // reset values
  localparam logic [15:0] BG_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] BG_OFFSET_RESET = 16'h0000;
  localparam logic [1:0] DEFECT_MODE_RESET = 2'h0;
  localparam logic [7:0] DEFECT_FILE_RESET = 8'h70;
  localparam logic [7:0] DRIFT_CONTROL_RESET = 8'h00;
  localparam logic [15:0] DRIFT_WORD_RESET = 16'h0000;
  // =====================================================================
  // mode encodings
  typedef enum logic [1:0] {OUT_PASS = 2'h0, OUT_APPLY = 2'h1, OUT_IMAGE = 2'h2} out_mode_t;
  localparam logic [2:0] INT_NONE = 3'h0;
  localparam logic [2:0] INT_1 = 3'h1;
  localparam logic [2:0] INT_8 = 3'h4;
  localparam logic [2:0] INT_16 = 3'h5;
  localparam logic [2:0] INT_32 = 3'h6;
  localparam logic [2:0] INT_64 = 3'h7;
endpackage : thermal_pkg
